// ---- bench/eirq_src_model.sv ----
// source model: interrupt pin with pull-up, free running oscillator
// assumes pclk from the bench; oscillator runs at a quarter of pclk
`timescale 1ns/10ps
module eirq_src_model (
  input  wire logic pclk,
  input  wire logic drive_low,
  output logic      pin_n,
  output logic      osc_clk
);
  // ----------------------------------------
  // pin and oscillator
  // ----------------------------------------
  logic [1:0] div_q = 2'h0;
  // released pin rises through the pull-up
  assign pin_n   = drive_low ? 1'b0 : 1'b1;
  assign osc_clk = div_q[1];
  always_ff @(posedge pclk) begin
    div_q <= div_q + 2'h1;
  end
endmodule // eirq_src_model

// ---- bench/testbench.sv ----
// self-checking bench for the external interrupt pin and wake block
// assumes eirq_top with shortened recovery counts and the source model
`timescale 1ns/10ps
`include "eirq_params.svh"
module testbench;
  localparam int N_LONG  = 16;
  localparam int N_SHORT = 4;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic        pin_low    = 1'b0;
  logic        vec_fetch  = 1'b0;
  logic        wait_enter = 1'b0;
  logic        stop_enter = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, pin_n, osc;
  logic        cpu_irq, wake, cpu_clk_run, sys_clk_run, irq;
  logic [15:0] irq_vector;
  logic [53:0] exp_q[$];
  int          miscompares = 0;
  int          check_count = 0;
  int          wake_cnt    = 0;
  integer      seed        = 32'hc50b;

  always #4 pclk = ~pclk;

  eirq_src_model SRC (.pclk(pclk), .drive_low(pin_low), .pin_n(pin_n), .osc_clk(osc));
  eirq_top #(.REC_LONG(N_LONG), .REC_SHORT(N_SHORT)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin_n(pin_n), .vec_fetch(vec_fetch), .wait_enter(wait_enter),
    .stop_enter(stop_enter), .osc_out_clock(osc), .cpu_irq(cpu_irq),
    .irq_vector(irq_vector), .wake(wake), .cpu_clk_run(cpu_clk_run),
    .sys_clk_run(sys_clk_run), .irq(irq));

  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge pclk) begin
    logic [53:0] got;
    logic [53:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      got = {pslverr, irq_vector, cpu_irq, wake, cpu_clk_run, sys_clk_run, irq, prdata};
      e   = (exp_q.size() == 0) ? ~got : exp_q.pop_front();
      check_count++;
      if (got !== e) begin
        miscompares++;
        $display("mismatch at %0t: got %h expected %h", $time, got, e);
      end
    end
  end

  // counts wake pulses
  always @(posedge pclk) begin
    if (wake === 1'b1) wake_cnt++;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test();
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("mismatch at %0t: reads left %h expected %h", $time, exp_q.size(), 0);
    end
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tmo();
    miscompares++;
    $display("mismatch at %0t: timeout got %h expected %h", $time, 1'b0, 1'b1);
    finish_test();
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // expected ports: cpu_irq, wake, cpu_clk_run, sys_clk_run, irq
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [4:0] p,
                    input logic err);
    exp_q.push_back({err, `EIRQ_VECTOR, p, d});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wsc(input logic mask, input logic mode, input logic ack);
    apb(1'b1, `EIRQ_OFF_SC, {28'h0, mode, mask, ack, 1'b0});
  endtask

  task automatic pin_pulse(input int w);
    pin_low <= 1'b1;
    repeat (w) @(posedge pclk);
    pin_low <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic strobe(input int which);
    if (which == 0) vec_fetch <= 1'b1;
    else if (which == 1) wait_enter <= 1'b1;
    else stop_enter <= 1'b1;
    @(posedge pclk);
    vec_fetch  <= 1'b0;
    wait_enter <= 1'b0;
    stop_enter <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic cmp_cnt(input int got, input int exp);
    check_count++;
    if (got < exp - 1 || got > exp + 1) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_eq(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // counts oscillator rises while the system clocks are held off
  task automatic wait_run(output int rises);
    int   n;
    logic last;
    n     = 0;
    rises = 0;
    last  = osc;
    while (sys_clk_run !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
      if (osc && !last) rises++;
      last = osc;
    end
    if (sys_clk_run !== 1'b1) tmo();
  endtask

  task automatic do_reset(input int cycles);
    int r;
    presetn <= 1'b0;
    repeat (cycles) @(posedge pclk);
    presetn <= 1'b1;
    wait_run(r);
    cmp_cnt(r, N_LONG);
    @(posedge pclk);
  endtask

  initial begin
    int r;
    do_reset(10);
    rd(`EIRQ_OFF_SC, 32'h30, 5'h06, 1'b0);
    rd(`EIRQ_OFF_CFG, 32'h0, 5'h06, 1'b0);
    rd(`EIRQ_OFF_EV_ST, 32'h2, 5'h06, 1'b0);
    rd(12'h010, 32'h0, 5'h06, 1'b1);
    $display("test reset done");
    pin_pulse(1 + ($random(seed) & 3));
    rd(`EIRQ_OFF_SC, 32'h31, 5'h16, 1'b0);
    wsc(1'b0, 1'b0, 1'b1);
    rd(`EIRQ_OFF_SC, 32'h30, 5'h06, 1'b0);
    pin_pulse(1 + ($random(seed) & 3));
    strobe(0);
    rd(`EIRQ_OFF_SC, 32'h30, 5'h06, 1'b0);
    $display("test edge done");
    wsc(1'b1, 1'b0, 1'b0);
    pin_pulse(1);
    rd(`EIRQ_OFF_SC, 32'h35, 5'h06, 1'b0);
    strobe(0);
    rd(`EIRQ_OFF_SC, 32'h35, 5'h06, 1'b0);
    wsc(1'b0, 1'b0, 1'b0);
    rd(`EIRQ_OFF_SC, 32'h31, 5'h16, 1'b0);
    wsc(1'b0, 1'b0, 1'b1);
    $display("test mask done");
    pin_pulse(2);
    pin_low <= 1'b1;
    repeat (3) @(posedge pclk);
    wsc(1'b0, 1'b0, 1'b1);
    rd(`EIRQ_OFF_SC, 32'h30, 5'h06, 1'b0);
    wsc(1'b0, 1'b1, 1'b1);
    rd(`EIRQ_OFF_SC, 32'h39, 5'h16, 1'b0);
    wsc(1'b0, 1'b1, 1'b1);
    rd(`EIRQ_OFF_SC, 32'h39, 5'h16, 1'b0);
    pin_low <= 1'b0;
    repeat (2) @(posedge pclk);
    rd(`EIRQ_OFF_SC, 32'h38, 5'h06, 1'b0);
    wsc(1'b0, 1'b1, 1'b1);
    rd(`EIRQ_OFF_SC, 32'h38, 5'h06, 1'b0);
    wsc(1'b0, 1'b0, 1'b0);
    $display("test level done");
    wsc(1'b1, 1'b0, 1'b0);
    strobe(1);
    rd(`EIRQ_OFF_SC, 32'h24, 5'h02, 1'b0);
    pin_pulse(1);
    rd(`EIRQ_OFF_SC, 32'h25, 5'h02, 1'b0);
    wsc(1'b0, 1'b0, 1'b0);
    rd(`EIRQ_OFF_SC, 32'h31, 5'h16, 1'b0);
    cmp_eq(wake_cnt, 1);
    strobe(0);
    rd(`EIRQ_OFF_SC, 32'h30, 5'h06, 1'b0);
    $display("test wait done");
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, `EIRQ_OFF_CFG, (s == 1) ? 32'h3 : 32'h0);
      apb(1'b1, `EIRQ_OFF_EV_ST, 32'h3);
      rd(`EIRQ_OFF_CFG, (s == 1) ? 32'h3 : 32'h0, 5'h06, 1'b0);
      strobe(2);
      rd(`EIRQ_OFF_SC, 32'h0, 5'h00, 1'b0);
      pin_low <= 1'b1;
      @(posedge pclk);
      pin_low <= 1'b0;
      wait_run(r);
      cmp_cnt(r, (s == 1) ? N_SHORT : N_LONG);
      rd(`EIRQ_OFF_SC, 32'h31, 5'h16, 1'b0);
      cmp_eq(wake_cnt, 3 - s);
      rd(`EIRQ_OFF_EV_ST, 32'h3, 5'h16, 1'b0);
      apb(1'b1, `EIRQ_OFF_EV_EN, 32'h2);
      rd(`EIRQ_OFF_EV_ST, 32'h3, 5'h17, 1'b0);
      apb(1'b1, `EIRQ_OFF_EV_ST, 32'h2);
      rd(`EIRQ_OFF_EV_ST, 32'h1, 5'h16, 1'b0);
      apb(1'b1, `EIRQ_OFF_EV_EN, 32'h1);
      rd(`EIRQ_OFF_EV_EN, 32'h1, 5'h17, 1'b0);
      apb(1'b1, `EIRQ_OFF_EV_EN, 32'h0);
      wsc(1'b0, 1'b0, 1'b1);
    end
    $display("test stop done");
    wsc(1'b1, 1'b1, 1'b0);
    pin_pulse(1);
    do_reset(2);
    rd(`EIRQ_OFF_SC, 32'h30, 5'h06, 1'b0);
    $display("test mid reset done");
    finish_test();
  end
endmodule // testbench

// ---- rtl/eirq_params.svh ----
// constants for the external interrupt pin and wake block
// assumes 12-bit APB byte addresses and 32-bit data
`ifndef EIRQ_PARAMS_SVH
`define EIRQ_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define EIRQ_OFF_SC       12'h000
`define EIRQ_OFF_CFG      12'h004
`define EIRQ_OFF_EV_ST    12'h008
`define EIRQ_OFF_EV_EN    12'h00c

// ----------------------------------------
// field positions
// ----------------------------------------
`define EIRQ_SC_LATCH     0
`define EIRQ_SC_ACK       1
`define EIRQ_SC_MASK      2
`define EIRQ_SC_MODE      3
`define EIRQ_SC_CPU_RUN   4
`define EIRQ_SC_SYS_RUN   5
`define EIRQ_CFG_SHORT    0
`define EIRQ_CFG_OSC_RUN  1
`define EIRQ_EV_PIN       0
`define EIRQ_EV_WAKE      1

// ----------------------------------------
// reset values
// ----------------------------------------
`define EIRQ_RST_MASK     1'b0
`define EIRQ_RST_MODE     1'b0
`define EIRQ_RST_SHORT    1'b0
`define EIRQ_VECTOR       16'hfffa

// ----------------------------------------
// timing counts in oscillator cycles, counter width in bits
// ----------------------------------------
`define EIRQ_REC_LONG     4096
`define EIRQ_REC_SHORT    32
`define EIRQ_REC_W        12

`endif

// ---- rtl/eirq_pin_det.sv ----
// falling edge and low level detect of the interrupt pin
// assumes the pin is already synchronous to pclk
`timescale 1ns/10ps
module eirq_pin_det (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_n,
  output logic      fall,
  output logic      low
);

  typedef struct packed {
    logic pin_q;
  } eirq_det_t;

  eirq_det_t s_q;
  eirq_det_t s_d;

  always_comb begin
    s_d       = s_q;
    s_d.pin_q = pin_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.pin_q <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign fall = s_q.pin_q & ~pin_n;
  assign low  = ~pin_n;

endmodule // eirq_pin_det

// ---- rtl/eirq_pkg.sv ----
// types for the external interrupt pin and wake block
// assumes nothing beyond a SystemVerilog compiler
package eirq_pkg;

  // ----------------------------------------
  // power states
  // ----------------------------------------
  typedef enum {
    EIRQ_RUN,
    EIRQ_WAIT,
    EIRQ_STOP,
    EIRQ_RECOVER
  } eirq_pwr_t;

endpackage : eirq_pkg

// ---- rtl/eirq_recovery.sv ----
// stop recovery hold-off counter in oscillator cycles
// assumes osc_clk is a sampled level, counted on its rising edge
`timescale 1ns/10ps
`include "eirq_params.svh"
module eirq_recovery #(
  parameter int REC_LONG  = `EIRQ_REC_LONG,
  parameter int REC_SHORT = `EIRQ_REC_SHORT
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic load,
  input  wire logic short_sel,
  input  wire logic osc_clk,
  output logic      done
);

  typedef struct packed {
    logic [`EIRQ_REC_W-1:0] cnt;
    logic                   busy;
    logic                   osc_q;
  } eirq_rec_t;

  eirq_rec_t s_q;
  eirq_rec_t s_d;
  logic      osc_rise;

  localparam logic [`EIRQ_REC_W-1:0] LONG_LD  = `EIRQ_REC_W'(REC_LONG - 1);
  localparam logic [`EIRQ_REC_W-1:0] SHORT_LD = `EIRQ_REC_W'(REC_SHORT - 1);

  assign osc_rise = osc_clk & ~s_q.osc_q;
  assign done     = s_q.busy & osc_rise & (s_q.cnt == '0);

  always_comb begin
    s_d       = s_q;
    s_d.osc_q = osc_clk;
    if (load) begin
      s_d.cnt  = short_sel ? SHORT_LD : LONG_LD;
      s_d.busy = 1'b1;
    end else if (s_q.busy && osc_rise) begin
      if (s_q.cnt == '0) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - `EIRQ_REC_W'(1);
      end
    end
  end

  // counting starts at reset, as after a reset wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.cnt   <= LONG_LD;
      s_q.busy  <= 1'b1;
      s_q.osc_q <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  property p_rec_short;
    @(posedge pclk) disable iff (!presetn)
    load && short_sel |=> s_q.busy && s_q.cnt == SHORT_LD;
  endproperty
  a_rec_short: assert property (p_rec_short) else $error("short load wrong");

  property p_rec_long;
    @(posedge pclk) disable iff (!presetn)
    load && !short_sel |=> s_q.busy && s_q.cnt == LONG_LD;
  endproperty
  a_rec_long: assert property (p_rec_long) else $error("long load wrong");

endmodule // eirq_recovery

// ---- rtl/eirq_top.sv ----
// external interrupt pin latch, mask and wait/stop wake control
// assumes APB master on pclk, pin and cpu strobes synchronous to pclk
`timescale 1ns/10ps
`include "eirq_params.svh"
module eirq_top #(
  parameter int REC_LONG  = `EIRQ_REC_LONG,
  parameter int REC_SHORT = `EIRQ_REC_SHORT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_pin_n,
  input  wire logic        vec_fetch,
  input  wire logic        wait_enter,
  input  wire logic        stop_enter,
  input  wire logic        osc_out_clock,
  output logic             cpu_irq,
  output logic      [15:0] irq_vector,
  output logic             wake,
  output logic             cpu_clk_run,
  output logic             sys_clk_run,
  output logic             irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic                latch;
    logic                lvl_acked;
    logic                mask;
    logic                mode;
    logic                short_rec;
    logic                osc_run;
    logic [1:0]          ev_st;
    logic [1:0]          ev_en;
    eirq_pkg::eirq_pwr_t pwr;
    logic                cpu_irq;
    logic [15:0]         vec;
    logic                wake;
    logic                cpu_run;
    logic                sys_run;
    logic                irq;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } eirq_top_st_t;

  eirq_top_st_t s_q;
  eirq_top_st_t s_d;

  logic fall;
  logic low;
  logic rec_load;
  logic rec_done;
  logic wr_acc;
  logic ack_sw;
  logic ack_vec;
  logic set;
  logic req;
  logic lvl_done;
  logic [1:0] ev_new;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    return a == `EIRQ_OFF_SC || a == `EIRQ_OFF_CFG ||
           a == `EIRQ_OFF_EV_ST || a == `EIRQ_OFF_EV_EN;
  endfunction

  function automatic logic [31:0] rd_mux(input logic [11:0] a, input eirq_top_st_t q);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      `EIRQ_OFF_SC: begin
        r[`EIRQ_SC_LATCH]   = q.latch;
        r[`EIRQ_SC_MASK]    = q.mask;
        r[`EIRQ_SC_MODE]    = q.mode;
        r[`EIRQ_SC_CPU_RUN] = q.cpu_run;
        r[`EIRQ_SC_SYS_RUN] = q.sys_run;
      end
      `EIRQ_OFF_CFG: begin
        r[`EIRQ_CFG_SHORT]   = q.short_rec;
        r[`EIRQ_CFG_OSC_RUN] = q.osc_run;
      end
      `EIRQ_OFF_EV_ST: r[1:0] = q.ev_st;
      `EIRQ_OFF_EV_EN: r[1:0] = q.ev_en;
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  eirq_pin_det u_det (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_n   (ext_irq_pin_n),
    .fall    (fall),
    .low     (low)
  );

  eirq_recovery #(
    .REC_LONG  (REC_LONG),
    .REC_SHORT (REC_SHORT)
  ) u_rec (
    .pclk      (pclk),
    .presetn   (presetn),
    .load      (rec_load),
    .short_sel (s_q.short_rec),
    .osc_clk   (osc_out_clock),
    .done      (rec_done)
  );

  // ----------------------------------------
  // latch and acknowledge
  // ----------------------------------------
  assign wr_acc  = psel & penable & s_q.pready & pwrite;
  assign ack_sw  = wr_acc & (paddr == `EIRQ_OFF_SC) & pwdata[`EIRQ_SC_ACK];
  assign ack_vec = vec_fetch & s_q.cpu_irq;
  assign set     = fall | (s_q.mode & low);
  assign req     = s_q.latch & ~s_q.mask;
  assign lvl_done = s_q.lvl_acked & s_q.mode & ~low;
  assign rec_load = (s_q.pwr == eirq_pkg::EIRQ_STOP) & req;

  always_comb begin
    s_d = s_q;
    ev_new = 2'h0;
    // set wins over clear; level mode keeps it while pin low
    // ack taken while low clears it once the pin is high again
    s_d.lvl_acked = s_q.mode & low & (s_q.lvl_acked | ack_sw | ack_vec);
    s_d.latch     = set | (s_q.latch & ~(ack_sw | ack_vec | lvl_done));
    ev_new[`EIRQ_EV_PIN] = set & ~s_q.latch;
    // register writes
    if (wr_acc) begin
      case (paddr)
        `EIRQ_OFF_SC: begin
          s_d.mask = pwdata[`EIRQ_SC_MASK];
          s_d.mode = pwdata[`EIRQ_SC_MODE];
        end
        `EIRQ_OFF_CFG: begin
          s_d.short_rec = pwdata[`EIRQ_CFG_SHORT];
          s_d.osc_run   = pwdata[`EIRQ_CFG_OSC_RUN];
        end
        `EIRQ_OFF_EV_ST: s_d.ev_st = s_q.ev_st & ~pwdata[1:0];
        `EIRQ_OFF_EV_EN: s_d.ev_en = pwdata[1:0];
        default: s_d.ev_en = s_q.ev_en;
      endcase
    end
    // power state
    case (s_q.pwr)
      eirq_pkg::EIRQ_RUN: begin
        if (stop_enter) begin
          s_d.pwr = eirq_pkg::EIRQ_STOP;
        end else if (wait_enter) begin
          s_d.pwr = eirq_pkg::EIRQ_WAIT;
        end
      end
      eirq_pkg::EIRQ_WAIT: begin
        if (req) begin
          s_d.pwr = eirq_pkg::EIRQ_RUN;
        end
      end
      eirq_pkg::EIRQ_STOP: begin
        if (req) begin
          s_d.pwr = eirq_pkg::EIRQ_RECOVER;
        end
      end
      eirq_pkg::EIRQ_RECOVER: begin
        if (rec_done) begin
          s_d.pwr = eirq_pkg::EIRQ_RUN;
          ev_new[`EIRQ_EV_WAKE] = 1'b1;
        end
      end
      default: s_d.pwr = eirq_pkg::EIRQ_RUN;
    endcase
    s_d.ev_st   = s_d.ev_st | ev_new;
    s_d.cpu_run = s_d.pwr == eirq_pkg::EIRQ_RUN;
    s_d.sys_run = s_d.pwr == eirq_pkg::EIRQ_RUN || s_d.pwr == eirq_pkg::EIRQ_WAIT;
    // request only once clocks run again
    s_d.cpu_irq = s_d.latch & ~s_d.mask & s_d.cpu_run;
    s_d.wake    = req & (s_q.pwr == eirq_pkg::EIRQ_WAIT ||
                         s_q.pwr == eirq_pkg::EIRQ_STOP);
    s_d.vec     = `EIRQ_VECTOR;
    s_d.irq     = |(s_d.ev_st & s_d.ev_en);
    // apb answer, one wait state
    s_d.pready  = psel & penable & ~s_q.pready;
    s_d.pslverr = psel & penable & ~s_q.pready & ~is_mapped(paddr);
    s_d.prdata  = (psel & penable & ~s_q.pready & ~pwrite) ? rd_mux(paddr, s_q) : 32'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.latch     <= 1'b0;
      s_q.lvl_acked <= 1'b0;
      s_q.mask      <= `EIRQ_RST_MASK;
      s_q.mode      <= `EIRQ_RST_MODE;
      s_q.short_rec <= `EIRQ_RST_SHORT;
      s_q.osc_run   <= 1'b0;
      s_q.ev_st     <= 2'h0;
      s_q.ev_en     <= 2'h0;
      s_q.pwr       <= eirq_pkg::EIRQ_RECOVER;
      s_q.cpu_irq   <= 1'b0;
      s_q.vec       <= `EIRQ_VECTOR;
      s_q.wake      <= 1'b0;
      s_q.cpu_run   <= 1'b0;
      s_q.sys_run   <= 1'b0;
      s_q.irq       <= 1'b0;
      s_q.pready    <= 1'b0;
      s_q.pslverr   <= 1'b0;
      s_q.prdata    <= 32'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign cpu_irq     = s_q.cpu_irq;
  assign irq_vector  = s_q.vec;
  assign wake        = s_q.wake;
  assign cpu_clk_run = s_q.cpu_run;
  assign sys_clk_run = s_q.sys_run;
  assign irq         = s_q.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_set;
    @(posedge pclk) disable iff (!presetn)
    fall |=> s_q.latch && (s_q.ev_st[`EIRQ_EV_PIN] || $past(s_q.latch));
  endproperty
  a_set: assert property (p_set) else $error("edge did not latch");

  property p_vec_clr;
    @(posedge pclk) disable iff (!presetn)
    ack_vec && !set |=> !s_q.latch;
  endproperty
  a_vec_clr: assert property (p_vec_clr) else $error("fetch did not clear");

  property p_sw_clr;
    @(posedge pclk) disable iff (!presetn)
    ack_sw && !set |=> !s_q.latch && !s_q.cpu_irq;
  endproperty
  a_sw_clr: assert property (p_sw_clr) else $error("ack did not clear");

  property p_edge_hold;
    @(posedge pclk) disable iff (!presetn)
    s_q.latch && !s_q.mode && !ack_sw && !ack_vec |=> s_q.latch;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("latch lost");

  property p_level_hold;
    @(posedge pclk) disable iff (!presetn)
    s_q.mode && low |=> s_q.latch;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("low pin dropped");

  property p_lvl_rel;
    @(posedge pclk) disable iff (!presetn)
    lvl_done |=> !s_q.latch;
  endproperty
  a_lvl_rel: assert property (p_lvl_rel) else $error("level latch kept");

  property p_mask;
    @(posedge pclk) disable iff (!presetn)
    s_q.mask |-> !s_q.cpu_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request out");

  property p_wait_wake;
    @(posedge pclk) disable iff (!presetn)
    s_q.pwr == eirq_pkg::EIRQ_WAIT && req |=> s_q.cpu_run && s_q.wake;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("no wait wake");

  property p_stop_hold;
    @(posedge pclk) disable iff (!presetn)
    rec_load |=> !s_q.sys_run [*8];
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("clocks too early");

  property p_clk_first;
    @(posedge pclk) disable iff (!presetn)
    s_q.cpu_irq |-> s_q.sys_run && s_q.cpu_run;
  endproperty
  a_clk_first: assert property (p_clk_first) else $error("irq w/o clocks");

endmodule // eirq_top
